// File: fpstat_map.svh
// Bit positions, reset values and encodings of the status register pair
`ifndef FPSTAT_MAP_SVH
`define FPSTAT_MAP_SVH

// Integer exception register, big-endian bit numbering mapped to [31-n]
`define IXR_SUMMARY_BIT 31
`define IXR_RANGE_BIT 30
`define IXR_WRAP_BIT 29
`define IXR_COUNT_LSB 0
`define IXR_COUNT_W 7
`define IXR_RESET 32'h0000_0000

// float status flags, architectural bit n sits at [31-n]
`define FSC_ANY 31
`define FSC_ENABLED 30
`define FSC_INVALID 29
`define FSC_OVF 28
`define FSC_UNF 27
`define FSC_ZDIV 26
`define FSC_INEXACT 25
`define FSC_SNAN 24
`define FSC_ISI 23
`define FSC_IDI 22
`define FSC_ZDZ 21
`define FSC_IMZ 20
`define FSC_VC 19
`define FSC_BUMPED 18
`define FSC_FRAC_INEXACT 17
`define FSC_CLASS_MSB 16
`define FSC_CLASS_LSB 12
`define FSC_SOFT 10
`define FSC_SQRT 9
`define FSC_CVI 8
`define FSC_VE 7
`define FSC_OE 6
`define FSC_UE 5
`define FSC_ZE 4
`define FSC_XE 3
`define FSC_NI 2
`define FSC_RN_MSB 1
`define FSC_RN_LSB 0
`define FSC_RESET 32'h0000_0000
// Bits carrying exception events (sticky) and the invalid-operation subset
`define FSC_STICKY_MASK 32'hfff8_0700
`define FSC_EXC_MASK 32'h1ff8_0700
`define FSC_INV_MASK 32'h01f8_0700
// Bits that events are allowed to set (software-request excluded)
`define FSC_EVENT_MASK 32'h1ff8_0300
`define FSC_WRITABLE 32'h9fff_f7ff

// Result class codes: class bit then less, greater, equal, unordered
`define RC_QNAN 5'h11
`define RC_NEG_INF 5'h09
`define RC_NEG_NORM 5'h08
`define RC_NEG_DENORM 5'h18
`define RC_NEG_ZERO 5'h12
`define RC_POS_ZERO 5'h02
`define RC_POS_DENORM 5'h14
`define RC_POS_NORM 5'h04
`define RC_POS_INF 5'h05

`endif

// File: fpstat_pkg.sv
// Types shared by the status and float register blocks
package fpstat_pkg;

    typedef enum logic [1:0] {
        RND_NEAREST,
        RND_ZERO,
        RND_PLUS_INF,
        RND_MINUS_INF
    } round_select_t;

    typedef enum logic [3:0] {
        IOP_NONE,
        IOP_ADD_OVF,
        IOP_MUL_DIV,
        IOP_CARRY_ADD,
        IOP_SHIFT_ARITH,
        IOP_MOVE_TO,
        IOP_COPY_TO_CR,
        IOP_STRING_COUNT
    } int_op_t;

    typedef enum logic [3:0] {
        FOP_NONE,
        FOP_ARITH,
        FOP_COMPARE,
        FOP_STATUS_COPY,
        FOP_FIELD_WRITE,
        FOP_IMM_FIELD_WRITE,
        FOP_BIT_CLEAR,
        FOP_BIT_SET
    } fp_op_t;

    // Integer completion report
    typedef struct packed {
        logic valid;
        int_op_t op;
        logic range_fault;
        logic wrap_out;
        logic [31:0] move_data;
    } int_report_t;

    // Float completion report; events use the status register bit layout
    typedef struct packed {
        logic valid;
        fp_op_t op;
        logic [31:0] events;
        logic affects_fi;
        logic fraction_inexact;
        logic mantissa_bumped;
        logic set_class;
        logic [4:0] result_class;
        logic [31:0] write_data;
        logic [31:0] write_mask;
        logic [4:0] bit_index;
        logic [2:0] copy_field;
        logic record;
    } fp_report_t;

    // Register file write port with unrounded operand
    typedef struct packed {
        logic valid;
        logic [4:0] index;
        logic single;
        logic sign;
        logic [11:0] exp;
        logic [55:0] mant;
    } fp_write_t;

    typedef struct packed {
        logic [3:0] cr_field;
        logic cr_valid;
    } cr_out_t;

endpackage

// File: fp_rounder.sv
// Rounds a wide intermediate to single or double and packs as double
`timescale 1ns/1ps
`default_nettype none
module fp_rounder (
    input wire logic sign, // Sign of the intermediate
    input wire logic [11:0] exp, // Biased double exponent, 0 for denormal
    input wire logic [55:0] mant, // Hidden bit, 52 fraction, 3 guard bits
    input wire logic single, // Round to single precision
    input wire fpstat_pkg::round_select_t mode, // Rounding mode
    input wire logic flush, // Produce signed zero for denormals
    output logic [63:0] result, // Double format result
    output logic inexact, // Rounding lost bits
    output logic bumped // Fraction was incremented
);
    import fpstat_pkg::*;
    logic [55:0] kept;
    logic [55:0] lost;
    logic [56:0] sum;
    logic up;
    logic half;
    logic above;
    logic lsb;
    always_comb
    begin
        kept = single ? {mant[55:32], 32'h0} : {mant[55:3], 3'h0};
        lost = mant & ~kept;
        inexact = |lost;
        half = single ? mant[31] : mant[2];
        above = single ? |mant[30:0] : |mant[1:0];
        lsb = single ? mant[32] : mant[3];
        case (mode)
            RND_NEAREST: up = half & (above | lsb);
            RND_ZERO: up = 1'b0;
            RND_PLUS_INF: up = inexact & ~sign;
            RND_MINUS_INF: up = inexact & sign;
            default: up = 1'b0;
        endcase
        sum = {1'b0, kept} + (up ? (single ? 57'h1_0000_0000 : 57'h8) : 57'h0);
        bumped = up;
        if (flush && exp == 12'h0)
        begin
            result = {sign, 63'h0};
            inexact = 1'b0;
            bumped = 1'b0;
        end
        else if (sum[56])
            result = {sign, exp[10:0] + 11'h1, sum[55:4]};
        else
            result = {sign, exp[10:0], sum[54:3]};
    end
endmodule // fp_rounder
`default_nettype wire

// File: fp_reg_bank.sv
// Thirty-two double-format float registers
`timescale 1ns/1ps
`default_nettype none
module fp_reg_bank #(
    parameter int COUNT = 32,
    parameter int WIDTH = 64
) (
    input wire logic clk, // Core clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic wr_en, // Write strobe
    input wire logic [4:0] wr_index, // Register written
    input wire logic [WIDTH-1:0] wr_data, // Double format value
    input wire logic [4:0] rd_index, // Register read
    output logic [WIDTH-1:0] rd_data // Registered read value
);
    typedef struct packed {
        logic [COUNT-1:0][WIDTH-1:0] float_regs;
        logic [WIDTH-1:0] rd;
    } bank_t;
    bank_t state_reg;
    bank_t state_next;
    if (COUNT != 32 || WIDTH != 64)
    begin : g_bad_size
        $error("fp_reg_bank serves only 32 registers of 64 bits");
    end
    always_comb
    begin
        state_next = state_reg;
        for (int i = 0; i < COUNT; i++)
        begin
            if (wr_en && wr_index == 5'(i))
                state_next.float_regs[i] = wr_data;
        end
        state_next.rd = state_reg.float_regs[rd_index];
    end
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end
    assign rd_data = state_reg.rd;
endmodule // fp_reg_bank
`default_nettype wire

// File: fp_status_core.sv
// Float registers, integer exception register and float status register
// What this block does
// - Thirty-two 64-bit float registers, read as double precision.
// - Round inexact results to target precision, store as double.
// - Summary overflow sets with overflow; cleared by move-to or copy-to-CR.
// - Move-to with summary 0 and overflow 1 leaves exactly that.
// - Add/subtract/negate with enable: overflow is msb carry mismatch.
// - Multiply-low/divide with enable: overflow when result unrepresentable.
// - Carrying and extended adds set carry from msb; others leave it.
// - Arithmetic right shift sets carry when ones leave negative operand.
// - Bits 25-31 hold string byte count; bits 3-24 reserved.
// - Status bits 0-23, control 24-31; status written at completion.
// - Exception bits sticky; cleared only by the status move instructions.
// - Any 0-to-1 exception sets summary bit, except field-write moves.
// - Enabled summary and invalid summary are ORs, not writable.
// - Individual sticky flags kept at their documented bit positions.
// - Inexact sticky ORs in new fraction-inexact when instruction affects it.
// - Bits 13 and 14 non-sticky: fraction bumped, fraction inexact.
// - Bits 15-19 class plus condition code; compares set one bit.
// - Result class codes follow the fixed nine-entry table.
// - Software-request invalid changes only through status move instructions.
// - Bits 24-28 are trap enables masking exceptions into enabled summary.
// - Two-bit rounding control selects nearest, zero, plus, minus.
// - Non-IEEE mode turns denormal results into signed zero.
// - Recording float instructions copy four summary flags to CR bits 4-7.
`include "fpstat_map.svh"
`timescale 1ns/1ps
`default_nettype none
module fp_status_core (
    input wire logic clk, // Core clock, 100 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input wire fpstat_pkg::int_report_t int_rpt, // Integer unit completion
    input wire fpstat_pkg::fp_report_t fp_rpt, // Float unit completion
    input wire fpstat_pkg::fp_write_t fp_wr, // Float register write, unrounded
    input wire logic [4:0] fp_rd_index, // Float register read select
    input wire logic [3:0] ixr_cr_sel, // Unused, no bit is read; tie off
    output logic [63:0] fp_rd_data, // Float register read data
    output logic [31:0] integer_exception_register, // Integer exception register
    output logic [31:0] float_status_control, // Float status and control
    output fpstat_pkg::cr_out_t cr_int, // Field copied by copy-to-CR
    output fpstat_pkg::cr_out_t cr_fp, // Float record or status copy field
    output fpstat_pkg::round_select_t round_select, // Active rounding mode
    output logic denormal_flush_mode // Non-IEEE mode
);
    import fpstat_pkg::*;

    typedef struct packed {
        logic [31:0] ixr;
        logic [31:0] fsc;
        cr_out_t cri;
        cr_out_t crf;
        logic [31:0] ixr_out;
        logic [31:0] fsc_out;
        logic [1:0] rn_out;
        logic ni_out;
    } core_t;

    core_t state_reg;
    core_t state_next;
    logic [63:0] rounded;
    logic round_inexact;
    logic round_bumped;
    logic [31:0] fsc_tmp;
    logic [31:0] prev;
    logic [31:0] ixr_tmp;
    logic any_rise;

    fp_rounder u_round (
        .sign(fp_wr.sign),
        .exp(fp_wr.exp),
        .mant(fp_wr.mant),
        .single(fp_wr.single),
        .mode(round_select_t'(state_reg.fsc[`FSC_RN_MSB:`FSC_RN_LSB])),
        .flush(state_reg.fsc[`FSC_NI]),
        .result(rounded),
        .inexact(round_inexact),
        .bumped(round_bumped)
    );

    fp_reg_bank #(
        .COUNT(32),
        .WIDTH(64)
    ) u_bank (
        .clk(clk),
        .rstn(rstn),
        .wr_en(fp_wr.valid),
        .wr_index(fp_wr.index),
        .wr_data(rounded),
        .rd_index(fp_rd_index),
        .rd_data(fp_rd_data)
    );

    // Recompute both summaries from stored flags and enables
    function automatic logic [31:0] summarize(input logic [31:0] v);
        logic [4:0] en;
        logic [4:0] ex;
        logic [31:0] r;
        en = v[`FSC_VE:`FSC_XE];
        ex = {v[`FSC_INVALID], v[`FSC_OVF], v[`FSC_UNF], v[`FSC_ZDIV], v[`FSC_INEXACT]};
        r = v;
        // invalid summary is the OR of invalid flags
        r[`FSC_INVALID] = |(v & `FSC_INV_MASK);
        ex[4] = r[`FSC_INVALID];
        // enables mask exceptions into enabled summary
        r[`FSC_ENABLED] = |(ex & en);
        r[11] = 1'b0;
        return r;
    endfunction

    always_comb
    begin
        state_next = state_reg;
        state_next.cri.cr_valid = 1'b0;
        state_next.crf.cr_valid = 1'b0;
        ixr_tmp = state_reg.ixr;
        fsc_tmp = state_reg.fsc;
        prev = state_reg.fsc;
        any_rise = 1'b0;

        if (int_rpt.valid)
        begin
            case (int_rpt.op)
                IOP_ADD_OVF, IOP_MUL_DIV:
                begin
                    ixr_tmp[`IXR_RANGE_BIT] = int_rpt.range_fault;
                    if (int_rpt.range_fault)
                        ixr_tmp[`IXR_SUMMARY_BIT] = 1'b1;
                    if (int_rpt.op == IOP_ADD_OVF && int_rpt.move_data[0])
                        ixr_tmp[`IXR_WRAP_BIT] = int_rpt.wrap_out;
                end
                IOP_CARRY_ADD: ixr_tmp[`IXR_WRAP_BIT] = int_rpt.wrap_out;
                IOP_SHIFT_ARITH: ixr_tmp[`IXR_WRAP_BIT] = int_rpt.wrap_out;
                IOP_MOVE_TO:
                begin
                    // move-to stores summary and overflow as given
                    ixr_tmp = int_rpt.move_data;
                    ixr_tmp[28:`IXR_COUNT_W] = '0;
                end
                IOP_COPY_TO_CR:
                begin
                    // copy-to-CR clears the flags it copies
                    state_next.cri.cr_field = {ixr_tmp[31:29], 1'b0};
                    state_next.cri.cr_valid = 1'b1;
                    ixr_tmp[31:29] = 3'h0;
                end
                IOP_STRING_COUNT:
                    ixr_tmp[`IXR_COUNT_W-1:0] = int_rpt.move_data[`IXR_COUNT_W-1:0];
                default: ixr_tmp = state_reg.ixr;
            endcase
        end

        // status bits change at completion reports and at float register writes
        if (fp_rpt.valid)
        begin
            case (fp_rpt.op)
                FOP_ARITH, FOP_COMPARE:
                begin
                    // events cannot touch the software-request flag
                    fsc_tmp = prev | (fp_rpt.events & `FSC_EVENT_MASK);
                    if (fp_rpt.affects_fi)
                    begin
                        fsc_tmp[`FSC_FRAC_INEXACT] = fp_rpt.fraction_inexact;
                        fsc_tmp[`FSC_BUMPED] = fp_rpt.mantissa_bumped;
                        fsc_tmp[`FSC_INEXACT] = prev[`FSC_INEXACT] | fp_rpt.fraction_inexact;
                    end
                    if (fp_rpt.op == FOP_COMPARE)
                    begin
                        // compares copy result_class[3:0] into the four condition bits, class bit kept
                        fsc_tmp[`FSC_CLASS_MSB-1:`FSC_CLASS_LSB] =
                            fp_rpt.result_class[3:0];
                    end
                    else if (fp_rpt.set_class)
                    begin
                        // class code as produced by the unit
                        fsc_tmp[`FSC_CLASS_MSB:`FSC_CLASS_LSB] = fp_rpt.result_class;
                    end
                    any_rise = |(fsc_tmp & ~prev & `FSC_EXC_MASK);
                    if (any_rise)
                        fsc_tmp[`FSC_ANY] = 1'b1;
                end
                FOP_STATUS_COPY:
                begin
                    // copy clears the exception bits of the field
                    state_next.crf.cr_field = 4'(prev >> (5'd28 - {fp_rpt.copy_field, 2'b0}));
                    state_next.crf.cr_valid = 1'b1;
                    fsc_tmp = prev & ~(((32'hf << 28) >> {fp_rpt.copy_field, 2'b0})
                        & `FSC_STICKY_MASK);
                end
                FOP_FIELD_WRITE, FOP_IMM_FIELD_WRITE:
                    fsc_tmp = (prev & ~(fp_rpt.write_mask & `FSC_WRITABLE))
                        | (fp_rpt.write_data & fp_rpt.write_mask & `FSC_WRITABLE);
                FOP_BIT_CLEAR:
                    fsc_tmp[5'd31 - fp_rpt.bit_index] = 1'b0;
                FOP_BIT_SET:
                begin
                    fsc_tmp[5'd31 - fp_rpt.bit_index] = 1'b1;
                    if (|(fsc_tmp & ~prev & `FSC_EXC_MASK))
                        fsc_tmp[`FSC_ANY] = 1'b1;
                end
                default: fsc_tmp = prev;
            endcase
            fsc_tmp = summarize(fsc_tmp);
            if (fp_rpt.record && fp_rpt.op != FOP_STATUS_COPY)
            begin
                state_next.crf.cr_field = fsc_tmp[31:28];
                state_next.crf.cr_valid = 1'b1;
            end
        end

        // inexact flags from the bank write
        if (fp_wr.valid && !(fp_rpt.valid && fp_rpt.affects_fi))
        begin
            fsc_tmp[`FSC_FRAC_INEXACT] = round_inexact;
            fsc_tmp[`FSC_BUMPED] = round_bumped;
            if (round_inexact && !prev[`FSC_INEXACT])
                fsc_tmp[`FSC_ANY] = 1'b1;
            fsc_tmp[`FSC_INEXACT] = fsc_tmp[`FSC_INEXACT] | round_inexact;
            fsc_tmp = summarize(fsc_tmp);
        end

        state_next.ixr = ixr_tmp;
        state_next.fsc = fsc_tmp;
        state_next.ixr_out = ixr_tmp;
        state_next.fsc_out = fsc_tmp;
        state_next.rn_out = fsc_tmp[`FSC_RN_MSB:`FSC_RN_LSB];
        state_next.ni_out = fsc_tmp[`FSC_NI];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= '0;
            state_reg.ixr <= `IXR_RESET;
            state_reg.fsc <= `FSC_RESET;
        end
        else
            state_reg <= state_next;
    end

    assign integer_exception_register = state_reg.ixr_out;
    assign float_status_control = state_reg.fsc_out;
    assign cr_int = state_reg.cri;
    assign cr_fp = state_reg.crf;
    assign round_select = round_select_t'(state_reg.rn_out);
    assign denormal_flush_mode = state_reg.ni_out;
endmodule // fp_status_core
`default_nettype wire

// File: fp_status_core_props.sv
// Concurrent checks on the status register pair
`include "fpstat_map.svh"
`timescale 1ns/1ps
`default_nettype none
module fp_status_core_props (
    input wire logic clk, // Core clock
    input wire logic rstn, // Reset, active low
    input wire fpstat_pkg::int_report_t int_rpt, // Integer completion
    input wire fpstat_pkg::fp_report_t fp_rpt, // Float completion
    input wire logic [31:0] integer_exception_register, // Integer flags
    input wire logic [31:0] float_status_control, // Float status
    input wire fpstat_pkg::cr_out_t cr_fp, // Float condition field
    input wire fpstat_pkg::round_select_t round_select, // Rounding mode
    input wire logic denormal_flush_mode // Flush mode
);
    import fpstat_pkg::*;
    logic iv;
    logic fv;
    logic fa;
    logic [31:0] ixr;
    logic [31:0] fsc;
    assign ixr = integer_exception_register;
    assign fsc = float_status_control;
    assign iv = int_rpt.valid;
    assign fv = fp_rpt.valid && fp_rpt.op inside {FOP_ARITH, FOP_COMPARE};
    assign fa = fp_rpt.valid && fp_rpt.op == FOP_ARITH;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sum_follows_a:
        assert property (iv && int_rpt.op inside {IOP_ADD_OVF, IOP_MUL_DIV} && int_rpt.range_fault
            |=> ixr[31] && ixr[30]) else $error("summary did not follow overflow");
    sum_sticky_a:
        assert property (ixr[31] && !(iv && int_rpt.op inside {IOP_MOVE_TO, IOP_COPY_TO_CR})
            |=> ixr[31]) else $error("summary dropped");
    move_exact_a:
        assert property (iv && int_rpt.op == IOP_MOVE_TO
            |=> ixr == ($past(int_rpt.move_data) & 32'he000_007f)) else $error("move mismatch");
    carry_keep_a:
        assert property (iv && int_rpt.op == IOP_MUL_DIV |=> $stable(ixr[29]))
            else $error("carry changed");
    reserved_zero_a:
        assert property (ixr[28:7] == 22'h0) else $error("reserved bits set");
    enabled_sum_a:
        assert property (fsc[30] == |(fsc[29:25] & fsc[7:3])) else $error("enabled summary");
    invalid_sum_a:
        assert property (fsc[29] == |(fsc & `FSC_INV_MASK)) else $error("invalid summary");
    soft_kept_a:
        assert property (fv |=> fsc[10] == $past(fsc[10])) else $error("soft flag moved");
    sticky_hold_a:
        assert property (fv |=> (($past(fsc) & ~fsc) & `FSC_EXC_MASK) == 32'h0)
            else $error("sticky bit cleared");
    any_summary_a:
        assert property (fa && |(fp_rpt.events & `FSC_EVENT_MASK & ~fsc) |=> fsc[31])
            else $error("exception summary not set");
    record_copy_a:
        assert property (fa && fp_rpt.record |=> cr_fp.cr_valid && cr_fp.cr_field == fsc[31:28])
            else $error("record field wrong");
    mode_out_a:
        assert property ({denormal_flush_mode, round_select} == fsc[2:0]) else $error("mode out");
endmodule // fp_status_core_props

bind fp_status_core fp_status_core_props i_props (.clk(clk), .rstn(rstn), .int_rpt(int_rpt),
    .fp_rpt(fp_rpt), .integer_exception_register(integer_exception_register),
    .float_status_control(float_status_control), .cr_fp(cr_fp), .round_select(round_select),
    .denormal_flush_mode(denormal_flush_mode));
`default_nettype wire

// File: exec_units.sv
// Stand-in for the execution units that report completions
`timescale 1ns/1ps
`default_nettype none
module exec_units (
    input wire logic clk, // Core clock
    output var fpstat_pkg::int_report_t int_rpt, // Integer completions
    output var fpstat_pkg::fp_report_t fp_rpt, // Float completions
    output var fpstat_pkg::fp_write_t fp_wr // Float register writes
);
    import fpstat_pkg::*;
    initial
    begin
        int_rpt = '0;
        fp_rpt = '0;
        fp_wr = '0;
    end
    // Idle for gap cycles, then hold one report across exactly one edge
    task automatic issue(input int_report_t ir, input fp_report_t fr, input fp_write_t wr,
        input int gap);
        if (gap > 0)
        begin
            int_rpt = '0;
            fp_rpt = '0;
            fp_wr = '0;
            repeat (gap) @(posedge clk);
            #1;
        end
        int_rpt = ir;
        fp_rpt = fr;
        fp_wr = wr;
        @(posedge clk);
        #1;
    endtask
endmodule // exec_units
`default_nettype wire

// File: fp_status_core_bench.sv
// Bench for the float registers and status registers
`include "fpstat_map.svh"
`timescale 1ns/1ps
`default_nettype none
module fp_status_core_bench;
    import fpstat_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] fp_rd_index = 5'h00;
    logic [31:0] seed = 32'h0000_0d0c;
    logic [31:0] want_ixr = 32'h0, want_fsc = 32'h0;
    logic [31:0] wmask = `FSC_WRITABLE;
    logic [4:0] rc [9] = '{`RC_QNAN, `RC_NEG_INF, `RC_NEG_NORM, `RC_NEG_DENORM, `RC_NEG_ZERO,
        `RC_POS_ZERO, `RC_POS_DENORM, `RC_POS_NORM, `RC_POS_INF};
    int_op_t iops [6] = '{IOP_ADD_OVF, IOP_MUL_DIV, IOP_CARRY_ADD, IOP_SHIFT_ARITH,
        IOP_STRING_COUNT, IOP_MOVE_TO};
    fp_op_t fops [8] = '{FOP_ARITH, FOP_ARITH, FOP_COMPARE, FOP_BIT_SET, FOP_BIT_CLEAR,
        FOP_STATUS_COPY, FOP_FIELD_WRITE, FOP_IMM_FIELD_WRITE};
    int bad_count = 0, cmp_count = 0;
    int_report_t int_rpt;
    fp_report_t fp_rpt;
    fp_write_t fp_wr;
    logic [63:0] fp_rd_data;
    logic [31:0] ixr, fsc;
    cr_out_t cr_fp, cr_int;
    round_select_t round_select;
    logic denormal_flush_mode;
    fp_report_t r;
    logic [31:0] v;

    always #5 clk = ~clk;

    exec_units i_units (.clk(clk), .int_rpt(int_rpt), .fp_rpt(fp_rpt), .fp_wr(fp_wr));
    fp_status_core i_dut (.clk(clk), .rstn(rstn), .int_rpt(int_rpt), .fp_rpt(fp_rpt),
        .fp_wr(fp_wr), .fp_rd_index(fp_rd_index), .ixr_cr_sel(4'h0), .fp_rd_data(fp_rd_data),
        .integer_exception_register(ixr), .float_status_control(fsc), .cr_int(cr_int),
        .cr_fp(cr_fp), .round_select(round_select), .denormal_flush_mode(denormal_flush_mode));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic fp_report_t fwrite(input logic [31:0] mask, input logic [31:0] data);
        fp_report_t f;
        f = '0;
        f.valid = 1'b1;
        f.op = FOP_FIELD_WRITE;
        f.write_mask = mask;
        f.write_data = data;
        return f;
    endfunction

    task automatic check(input string what, input logic [63:0] e, input logic [63:0] got);
        cmp_count++;
        if (got !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic int_op(input int_op_t op, input logic rf, input logic wo,
        input logic [31:0] d, input int gap);
        int_report_t ir;
        ir = '{1'b1, op, rf, wo, d};
        i_units.issue(ir, '0, '0, gap);
        if (op == IOP_COPY_TO_CR)
            check("cr_int", {want_ixr[31:29], 2'b01}, cr_int);
        case (op)
            IOP_ADD_OVF, IOP_MUL_DIV:
            begin
                want_ixr[30] = rf;
                want_ixr[31] |= rf;
                if (op == IOP_ADD_OVF && d[0])
                    want_ixr[29] = wo;
            end
            IOP_CARRY_ADD, IOP_SHIFT_ARITH: want_ixr[29] = wo;
            IOP_MOVE_TO: want_ixr = d & 32'he000_007f;
            IOP_STRING_COUNT: want_ixr[6:0] = d[6:0];
            IOP_COPY_TO_CR: want_ixr[31:29] = 3'h0;
            default: ;
        endcase
        check("integer_exception_register", want_ixr, ixr);
    endtask

    task automatic fp_op(input fp_report_t f, input logic [31:0] msk);
        logic [31:0] old;
        logic [3:0] ecr;
        old = want_fsc;
        ecr = old[31 - 4 * f.copy_field -: 4];
        i_units.issue('0, f, '0, 0);
        case (f.op)
            FOP_ARITH, FOP_COMPARE:
            begin
                want_fsc |= f.events & `FSC_EVENT_MASK;
                if (f.affects_fi)
                begin
                    want_fsc[`FSC_FRAC_INEXACT] = f.fraction_inexact;
                    want_fsc[`FSC_BUMPED] = f.mantissa_bumped;
                    want_fsc[`FSC_INEXACT] |= f.fraction_inexact;
                end
                if (f.op == FOP_COMPARE)
                    want_fsc[15:12] = f.result_class[3:0];
                else if (f.set_class)
                    want_fsc[16:12] = f.result_class;
            end
            FOP_FIELD_WRITE, FOP_IMM_FIELD_WRITE:
                want_fsc = (want_fsc & ~(f.write_mask & wmask)) | (f.write_data & f.write_mask & wmask);
            FOP_BIT_SET: want_fsc[31 - f.bit_index] |= wmask[31 - f.bit_index];
            FOP_BIT_CLEAR: want_fsc[31 - f.bit_index] &= ~wmask[31 - f.bit_index];
            FOP_STATUS_COPY: want_fsc &= ~(`FSC_STICKY_MASK & (32'hf000_0000 >> (4 * f.copy_field)));
            default: ;
        endcase
        if (!(f.op inside {FOP_FIELD_WRITE, FOP_IMM_FIELD_WRITE}) && |(want_fsc & ~old & `FSC_EXC_MASK))
            want_fsc[31] = 1'b1;
        want_fsc[29] = |(want_fsc & `FSC_INV_MASK);
        want_fsc[30] = |(want_fsc[29:25] & want_fsc[7:3]);
        if (f.op == FOP_ARITH)
            ecr = want_fsc[31:28];
        check("float_status_control", want_fsc & msk, fsc & msk);
        if (f.record || f.op == FOP_STATUS_COPY)
            check("cr_fp", {1'b1, ecr}, {cr_fp.cr_valid, cr_fp.cr_field});
    endtask

    task automatic store(input fp_write_t w, input logic [63:0] e);
        i_units.issue('0, '0, w, 0);
        fp_rd_index = w.index;
        i_units.issue('0, '0, '0, 0);
        check("fp_rd_data", e, fp_rd_data);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        bad_count++;
        complete_run();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        rstn = 1'b1;
        check("reset ixr", 64'h0, ixr);
        check("reset fsc", 64'h0, fsc);
        int_op(IOP_MOVE_TO, 1'b0, 1'b0, 32'h4000_0000, 0);
        int_op(IOP_CARRY_ADD, 1'b0, 1'b1, 32'h0, 0);
        int_op(IOP_ADD_OVF, 1'b1, 1'b0, 32'h0, 0);
        int_op(IOP_COPY_TO_CR, 1'b0, 1'b0, 32'h0, 0);
        int_op(IOP_MOVE_TO, 1'b1, 1'b1, 32'hffff_ffff, 1);
        for (int i = 0; i < 40; i++)
        begin
            v = rnd();
            int_op(iops[v[2:0] % 6], v[3], v[4], rnd(), int'(v[5]));
        end
        for (int i = 0; i < 80; i++)
        begin
            v = rnd();
            r = '0;
            r.valid = 1'b1;
            r.op = fops[v[23:21]];
            r.events = rnd() & (`FSC_EVENT_MASK | 32'h0000_0400);
            r.affects_fi = v[0];
            r.fraction_inexact = v[1];
            r.mantissa_bumped = v[2];
            r.set_class = v[3] || r.op == FOP_COMPARE;
            r.record = v[4] && r.op == FOP_ARITH;
            r.bit_index = v[9:5];
            r.copy_field = v[12:10];
            r.result_class = (r.op == FOP_COMPARE) ? 5'(1 << v[14:13]) : rc[v[20:16] % 9];
            r.write_mask = rnd();
            r.write_data = rnd();
            fp_op(r, 32'hffff_ffff);
        end
        fp_op(fwrite(32'hffff_ffff, 32'h0), 32'hffff_ffff);
        for (int m = 0; m < 4; m++)
        begin
            fp_op(fwrite(32'h7, 32'(m)), 32'h7df9_ffff);
            check("round_select", 64'(m), round_select);
            store('{1'b1, 5'(m), 1'b0, 1'b1, 12'h400, {1'b1, 52'h1, 3'b010}},
                {1'b1, 11'h400, 52'h1 + 52'(m == 3)});
        end
        fp_op(fwrite(32'h7, 32'h4), 32'h7df9_ffff);
        store('{1'b1, 5'h1f, 1'b0, 1'b1, 12'h000, {1'b0, 52'h8, 3'b000}}, 64'h8000_0000_0000_0000);
        check("denormal_flush_mode", 64'h1, denormal_flush_mode);
        fp_op(fwrite(32'hffff_ffff, 32'h0), 32'hffff_ffff);
        i_units.issue('0, '0, '0, 0);
        complete_run();
    end
endmodule // fp_status_core_bench
`default_nettype wire
